// file: acs_chk.sv
// Port assertions for the sequencer
`timescale 1ns/1ps
module acs_chk
  import acs_pkg::*;
#(
  parameter logic [17:0] CAL_FULL_TICKS = ACS_CAL_FULL_TICKS,
  parameter logic [17:0] CAL_DAC_TICKS = ACS_CAL_DAC_TICKS,
  parameter logic [17:0] CAL_OFS_TICKS = ACS_CAL_OFS_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins and controls
  input wire logic convert_trigger_n,
  input wire logic cal_trigger,
  input wire logic din_oe,
  input wire logic sw_convert,
  input wire logic [1:0] cal_type,
  input wire logic bidir_mode,
  // Status
  input wire logic busy,
  input wire acs_status_t status,
  input wire logic conv_done,
  input wire logic cal_done
);
  logic [19:0] cnt;
  logic [19:0] n4;
  logic [1:0] ty;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ========================
  // Busy length, type held while busy
  always_ff @(posedge mclk) begin
    cnt <= busy ? cnt + 20'h1 : 20'h0;
    ty <= busy ? ty : cal_type;
  end
  assign n4 = 20'(4 * (ty == ACS_CAL_DAC ? CAL_DAC_TICKS : ty == ACS_CAL_OFS ? CAL_OFS_TICKS : CAL_FULL_TICKS));
  // Busy and done timing
  property p_cal; cal_done |-> cnt + 20'h5 > n4 && cnt < n4 + 20'h2; endproperty
  a_cal: assert property (p_cal) else $error("cal");
  property p_bcal; $rose(cal_trigger) && !busy |-> ##[3:10] busy && status.calibrating; endproperty
  a_bcal: assert property (p_bcal) else $error("bcal");
  property p_bcnv; $fell(convert_trigger_n) && !busy |-> ##[3:10] busy && status.converting; endproperty
  a_bcnv: assert property (p_bcnv) else $error("bcnv");
  property p_cnv; $rose(convert_trigger_n) && status.converting |-> ##[70:84] conv_done; endproperty
  a_cnv: assert property (p_cnv) else $error("cnv");
  property p_sw; sw_convert && !busy && convert_trigger_n |-> ##[1:2] busy ##[70:84] conv_done; endproperty
  a_sw: assert property (p_sw) else $error("sw");
  property p_done; $fell(busy) |-> (conv_done ^ cal_done) && status == ACS_STATUS_RST; endproperty
  a_done: assert property (p_done) else $error("done");
  property p_off; !bidir_mode && !$past(bidir_mode, 2) |-> !din_oe; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_oe; $rose(din_oe) |-> bidir_mode; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  c_cnv: cover property (conv_done);
  c_cal: cover property (cal_done && ty == ACS_CAL_OFS);
  c_oe: cover property ($rose(din_oe));
endmodule
bind acs_sequencer acs_chk #(.CAL_FULL_TICKS(CAL_FULL_TICKS), .CAL_DAC_TICKS(CAL_DAC_TICKS),
  .CAL_OFS_TICKS(CAL_OFS_TICKS)) i_chk (.*);

// file: acs_host.sv
// Host model driving converter pins and frames
`timescale 1ns/1ps
module acs_host (
  // Clock and device outputs
  input wire logic mclk,
  input wire logic din_o,
  input wire logic din_oe,
  // Pins
  output logic mci,
  output logic cnv_n,
  output logic cal,
  output logic sclk,
  output logic frm_n,
  output logic hd
);
  logic [1:0] ph = 2'h0;
  logic [15:0] cap;
  int n;
  // ========================
  // Master clock of four cycles; released line toggles
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    hd <= ~ph[0];
  end
  assign mci = ph[1];
  initial {cal, sclk, cnv_n, frm_n} = 4'h3;
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Trigger after the acquisition gap
  task automatic trig(input bit c);
    cyc(17);
    if (c) begin
      cal <= 1'b1;
    end else begin
      cnv_n <= 1'b0;
    end
    cyc(10);
    cal <= 1'b0;
    cnv_n <= 1'b1;
  endtask
  // 17 clocks, driven bits shifted into cap
  task automatic frame;
    cap = 16'h0;
    n = 0;
    frm_n <= 1'b0;
    cyc(4);
    repeat (17) begin
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
      cyc(4);
      if (din_oe) begin
        cap = {cap[14:0], din_o};
        n++;
      end
    end
    // Hold the frame high long enough for the synchroniser to see the gap
    frm_n <= 1'b1;
    cyc(4);
  endtask
endmodule

// file: acs_pin_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module acs_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous pin
  input wire logic pin,
  // Synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic prev;

  // Chain of three flops; only the second stage reads the first
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= RST_VAL;
      stable <= RST_VAL;
      prev <= RST_VAL;
    end else begin
      meta <= pin;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edge pulses from the settled stages
  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;

endmodule

// file: acs_pkg.sv
// Constants, state codes and carriers for the conversion and calibration sequencer
// Contract
// - A conversion finishes within twenty master clock periods of its trigger; the code counts the twenty periods from the trigger's rising edge.
// - Full self-calibration lasts 250026 master clock periods before completion is reported.
// - DAC plus system full-scale calibration lasts 222228 master clock periods.
// - System offset calibration lasts 27798 master clock periods.
// - Busy rises within 2.5 master clock periods of a convert fall or calibrate rise.
// - A software convert command starts a conversion just like the trigger pin.
// - In bidirectional mode the device drives data-in after a clock edge, then releases it.
// - Busy stays high from trigger until the conversion or calibration completes.
package acs_pkg;

  // ==========================================================
  // Sequence lengths in master clock periods
  localparam int unsigned ACS_CNT_W = 18;
  localparam logic [17:0] ACS_CONV_TICKS = 18'h00014;    // 20 periods
  localparam logic [17:0] ACS_CAL_FULL_TICKS = 18'h3D0AA; // 250026 periods
  localparam logic [17:0] ACS_CAL_DAC_TICKS = 18'h36414;  // 222228 periods
  localparam logic [17:0] ACS_CAL_OFS_TICKS = 18'h06C96;  // 27798 periods
  localparam logic [17:0] ACS_CNT_RST = 18'h00000;

  // ==========================================================
  // Serial frame turnaround of the data-in line
  localparam logic [4:0] ACS_TURN_BIT = 5'h08;
  localparam logic [4:0] ACS_FRAME_BITS = 5'h10;
  localparam logic [4:0] ACS_BIT_RST = 5'h00;

  // ==========================================================
  // Calibration type codes
  localparam logic [1:0] ACS_CAL_FULL = 2'h0;
  localparam logic [1:0] ACS_CAL_DAC = 2'h1;
  localparam logic [1:0] ACS_CAL_OFS = 2'h2;

  // ==========================================================
  // Sequencer states and status carrier
  typedef enum logic [3:0] {
    ACS_IDLE = 4'h1,
    ACS_ARMED = 4'h2,
    ACS_CONV = 4'h4,
    ACS_CAL = 4'h8
  } acs_state_t;

  typedef struct packed {
    logic busy;
    logic converting;
    logic calibrating;
  } acs_status_t;

  localparam acs_status_t ACS_STATUS_RST = 3'h0;

endpackage

// file: acs_sequencer.sv
// Conversion and calibration sequencer with data-in turnaround control
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter logic [17:0] CAL_FULL_TICKS = ACS_CAL_FULL_TICKS,
  parameter logic [17:0] CAL_DAC_TICKS = ACS_CAL_DAC_TICKS,
  parameter logic [17:0] CAL_OFS_TICKS = ACS_CAL_OFS_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Device pins
  input wire logic master_clock_in,
  input wire logic convert_trigger_n,
  input wire logic cal_trigger,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic din_i,
  output logic din_o,
  output logic din_oe,
  // Same-clock user side
  input wire logic sw_convert,
  input wire logic [1:0] cal_type,
  input wire logic bidir_mode,
  input wire logic [15:0] readback_word,
  // Status
  output logic busy,
  output acs_status_t status,
  output logic conv_done,
  output logic cal_done
);

  // ==========================================================
  // Pin synchronisers
  logic master_clock_in_tick;
  logic conv_rise;
  logic conv_fall;
  logic cal_rise;
  logic sclk_rise;
  logic frame_level;
  logic frame_fall;

  acs_pin_sync #(.RST_VAL(1'b0)) u_master_clock_in (
    .mclk(mclk),
    .rst(rst),
    .pin(master_clock_in),
    .level(),
    .rise(master_clock_in_tick),
    .fall()
  );

  acs_pin_sync #(.RST_VAL(1'b1)) u_conv (
    .mclk(mclk),
    .rst(rst),
    .pin(convert_trigger_n),
    .level(),
    .rise(conv_rise),
    .fall(conv_fall)
  );

  acs_pin_sync #(.RST_VAL(1'b0)) u_cal (
    .mclk(mclk),
    .rst(rst),
    .pin(cal_trigger),
    .level(),
    .rise(cal_rise),
    .fall()
  );

  acs_pin_sync #(.RST_VAL(1'b0)) u_sclk (
    .mclk(mclk),
    .rst(rst),
    .pin(sclk),
    .level(),
    .rise(sclk_rise),
    .fall()
  );

  acs_pin_sync #(.RST_VAL(1'b1)) u_frame (
    .mclk(mclk),
    .rst(rst),
    .pin(frame_n),
    .level(frame_level),
    .rise(),
    .fall(frame_fall)
  );

  // ==========================================================
  // Sequencer state
  acs_state_t state;
  acs_state_t next_state;
  logic [17:0] count;
  logic [17:0] next_count;
  logic [17:0] target;
  logic [17:0] next_target;
  logic next_conv_done;
  logic next_cal_done;
  acs_status_t next_status;

  // Next state, tick counter and completion pulses
  always_comb begin
    next_state = state;
    next_count = count;
    next_target = target;
    next_conv_done = 1'b0;
    next_cal_done = 1'b0;
    case (state)
      ACS_IDLE: begin
        if (cal_rise) begin
          next_state = ACS_CAL;
          next_count = ACS_CNT_RST;
          case (cal_type)
            ACS_CAL_DAC: next_target = CAL_DAC_TICKS;
            ACS_CAL_OFS: next_target = CAL_OFS_TICKS;
            default: next_target = CAL_FULL_TICKS;
          endcase
        end else if (conv_fall) begin
          next_state = ACS_ARMED;
        end else if (sw_convert) begin
          next_state = ACS_CONV;
          next_count = ACS_CNT_RST;
        end
      end
      ACS_ARMED: begin
        // Hold starts on the rising edge of the trigger
        if (conv_rise) begin
          next_state = ACS_CONV;
          next_count = ACS_CNT_RST;
        end
      end
      ACS_CONV: begin
        if (master_clock_in_tick) begin
          if (count == ACS_CONV_TICKS - 18'h00001) begin
            next_state = ACS_IDLE;
            next_conv_done = 1'b1;
          end else begin
            next_count = count + 18'h00001;
          end
        end
      end
      ACS_CAL: begin
        if (master_clock_in_tick) begin
          if (count == target - 18'h00001) begin
            next_state = ACS_IDLE;
            next_cal_done = 1'b1;
          end else begin
            next_count = count + 18'h00001;
          end
        end
      end
      default: begin
        next_state = ACS_IDLE;
        next_count = ACS_CNT_RST;
      end
    endcase
    // Busy covers every state but idle, from trigger to completion
    next_status.busy = (next_state != ACS_IDLE);
    next_status.converting = (next_state == ACS_CONV) || (next_state == ACS_ARMED);
    next_status.calibrating = (next_state == ACS_CAL);
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ACS_IDLE;
      count <= ACS_CNT_RST;
      target <= ACS_CNT_RST;
      status <= ACS_STATUS_RST;
      conv_done <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      target <= next_target;
      status <= next_status;
      conv_done <= next_conv_done;
      cal_done <= next_cal_done;
    end
  end

  assign busy = status.busy;

  // ==========================================================
  // Data-in turnaround in bidirectional mode
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic next_din_o;
  logic next_din_oe;
  logic [3:0] bit_idx;

  // Counts clock edges in a frame; drives the readback half only
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_din_o = din_o;
    next_din_oe = din_oe;
    bit_idx = 4'hF - bit_cnt[3:0];
    if (frame_level) begin
      next_bit_cnt = ACS_BIT_RST;
      next_din_oe = 1'b0;
    end else if (frame_fall) begin
      next_bit_cnt = ACS_BIT_RST;
      next_din_oe = 1'b0;
    end else if (sclk_rise) begin
      if (bit_cnt != ACS_FRAME_BITS) begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
      if (bidir_mode && (bit_cnt >= ACS_TURN_BIT) && (bit_cnt < ACS_FRAME_BITS)) begin
        next_din_oe = 1'b1;
        next_din_o = readback_word[bit_idx];
      end else begin
        next_din_oe = 1'b0;
      end
    end
  end

  // Turnaround registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_cnt <= ACS_BIT_RST;
      din_o <= 1'b0;
      din_oe <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      din_o <= next_din_o;
      din_oe <= next_din_oe;
    end
  end

endmodule

// file: test_adc_conversion_calibration_sequencer.sv
// Bench for the conversion and calibration sequencer
`timescale 1ns/1ps
module test_adc_conversion_calibration_sequencer;
  import acs_pkg::*;
  logic mclk, mci, cnv_n, cal, sclk, frm_n, hd, din_o, din_oe, busy, conv_done, cal_done;
  logic rst = 1'b1;
  logic sw;
  logic bidir;
  logic [1:0] ct;
  logic [15:0] word;
  acs_status_t status;
  int mismatches, samples_checked, len, t;
  int seed = 32'h3258;
  acs_host i_host (.mclk, .din_o, .din_oe, .mci, .cnv_n, .cal, .sclk, .frm_n, .hd);
  acs_sequencer #(.CAL_FULL_TICKS(18'h00010), .CAL_DAC_TICKS(18'h0000C), .CAL_OFS_TICKS(18'h00008)) i_dut (
    .mclk, .rst, .master_clock_in(mci), .convert_trigger_n(cnv_n), .cal_trigger(cal), .sclk, .frame_n(frm_n),
    .din_i(din_oe ? din_o : hd), .din_o, .din_oe, .sw_convert(sw), .cal_type(ct), .bidir_mode(bidir),
    .readback_word(word), .busy, .status, .conv_done, .cal_done);
  // ========================
  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Busy cycles for a calibration type
  function automatic int cal_n(input int k);
    return 4 * (k == 1 ? 12 : k == 2 ? 8 : 16);
  endfunction
  // Length of the next busy interval
  task automatic span;
    len = 0;
    for (int i = 0; i < 200 && busy !== 1'b1; i++) @(posedge mclk);
    while (busy === 1'b1 && len < 3000) begin
      @(posedge mclk);
      len++;
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog far past the some 1200 cycles needed
  initial begin
    #100us;
    mismatches++;
    results;
  end
  // Main sequence
  initial begin
    // Start-up values; random ones already reach the pins during reset
    sw <= 1'b0;
    bidir <= 1'($random(seed));
    ct <= 2'($random(seed));
    word <= 16'($random(seed));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("idle", 18'h0, {busy, status, din_oe});
    for (int k = 0; k < 4; k++) begin
      word <= 16'($random(seed));
      bidir <= k[0];
      fork
        i_host.trig(0);
        span;
        i_host.frame;
      join
      check("conv len", 1, len > 83 && len < 92);
      check("din n", k[0] ? 8 : 0, i_host.n);
      check("din", k[0] ? word[7:0] : 0, i_host.cap);
      $display("conversion %0d ended", k);
    end
    // Software start; a second one while busy is ignored
    i_host.cyc(17);
    sw <= 1'b1;
    @(posedge mclk);
    sw <= 1'b0;
    i_host.cyc(2);
    check("sw busy", 18'hE, {busy, status});
    sw <= 1'b1;
    @(posedge mclk);
    sw <= 1'b0;
    span;
    i_host.cyc(10);
    check("sw len", 1, len > 70 && len < 84);
    check("refused", 0, busy);
    $display("software conversion ended");
    for (int k = 0; k < 6; k++) begin
      t = k < 4 ? k : $random(seed) & 3;
      ct <= t[1:0];
      fork
        i_host.trig(1);
        span;
      join
      check("cal len", 1, len > cal_n(t) - 6 && len < cal_n(t) + 3);
      $display("calibration %0d ended", k);
    end
    results;
  end
endmodule
